// file: pchr_arb_model.sv
`timescale 1ns/1ps

// Bus arbiter stand-in: owns the grant pin and removes it on command.
module pchr_arb_model (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic hold_grant,
    output logic      pci_gnt_n
);
    // Grant follows the host's wish one clock late, as a real arbiter would.
    // Out of reset nobody is granted, so the pin idles high.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pci_gnt_n <= 1'b1;
        end else begin
            pci_gnt_n <= ~hold_grant;
        end
    end
endmodule

// file: pchr_lat_timer.sv
`timescale 1ns/1ps

// Master latency timer: counts PCI clocks from FRAME and asks for an early end.
module pchr_lat_timer #(
    parameter int TIMER_W = 8
) (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic [TIMER_W-1:0] timer_limit,
    input  wire logic               frame_start,
    input  wire logic               xfer_done,
    input  wire logic               gnt_n_sync,
    output logic                    timer_expired,
    output logic                    end_req
);

    if (TIMER_W < 1 || TIMER_W > 16) begin : g_bad_width
        $error("pchr_lat_timer: TIMER_W must lie between 1 and 16.");
    end

    pchr_pkg::pchr_lt_state_e state_reg;
    logic [TIMER_W-1:0]       cnt_reg;

    // A new FRAME always restarts from zero, even over a finishing transfer.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= pchr_pkg::LT_IDLE;
            cnt_reg   <= '0;
        end else if (frame_start) begin
            state_reg <= pchr_pkg::LT_COUNT;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                pchr_pkg::LT_IDLE: begin
                    cnt_reg <= '0;
                end
                pchr_pkg::LT_COUNT: begin
                    if (xfer_done) begin
                        state_reg <= pchr_pkg::LT_IDLE;
                    end else if (cnt_reg == timer_limit) begin
                        state_reg <= pchr_pkg::LT_EXPIRED;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                pchr_pkg::LT_EXPIRED: begin
                    if (xfer_done) begin
                        state_reg <= pchr_pkg::LT_IDLE;
                    end
                end
                default: begin
                    state_reg <= pchr_pkg::LT_IDLE;
                end
            endcase
        end
    end

    // The early end waits for the arbiter to take the grant away, so a
    // master that keeps its grant may run on past the count.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            end_req       <= 1'b0;
            timer_expired <= 1'b0;
        end else begin
            end_req       <= (state_reg == pchr_pkg::LT_EXPIRED) && gnt_n_sync
                             && !xfer_done && !frame_start;
            timer_expired <= (state_reg == pchr_pkg::LT_EXPIRED) && !frame_start;
        end
    end

    sequence s_frame;
        frame_start;
    endsequence

    a_restart_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_frame |=> (cnt_reg == '0) && (state_reg == pchr_pkg::LT_COUNT))
        else $error("Latency count did not restart at FRAME.");

    a_end_on_gnt: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == pchr_pkg::LT_EXPIRED) && gnt_n_sync && !xfer_done && !frame_start
        |=> end_req)
        else $error("Expired transfer not ended after grant removal.");

    a_no_early_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        end_req |-> ($past(state_reg) == pchr_pkg::LT_EXPIRED) && $past(gnt_n_sync))
        else $error("End request raised before expiry or with grant held.");

    a_expiry_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == pchr_pkg::LT_COUNT) && !xfer_done && !frame_start
        && (cnt_reg == timer_limit) |=> state_reg == pchr_pkg::LT_EXPIRED)
        else $error("Latency timer did not expire at the programmed count.");

endmodule

// file: pchr_pkg.sv
package pchr_pkg;

    // Printed configuration offsets, as byte addresses.
    localparam logic [7:0]  OFS_LINE_TIMER   = 8'h0c;
    localparam logic [7:0]  OFS_HDR_SELFTEST = 8'h0e;
    localparam logic [7:0]  OFS_WIN_BASE     = 8'h10;

    // Field positions inside the dword at 0Ch.
    localparam int          LINE_LSB         = 0;
    localparam int          TIMER_LSB        = 8;
    localparam int          HDR_LSB          = 16;
    localparam int          SELFTEST_LSB     = 24;

    // Field positions inside the window base register.
    localparam int          PTR_LSB          = 11;
    localparam int          PREFETCH_BIT     = 3;
    localparam int          LOCATE_LSB       = 1;
    localparam int          SPACE_BIT        = 0;

    // Reset and fixed read values.
    localparam logic [15:0] LINE_TIMER_RESET = 16'h0000;
    localparam logic [15:0] HDR_SELF_VALUE   = 16'h0000;
    localparam logic [7:0]  SELFTEST_VALUE   = 8'h00;
    localparam logic [7:0]  HEADER_LAYOUT    = 8'h00;
    localparam logic [31:0] WIN_BASE_RESET   = 32'h00000000;
    localparam logic        PREFETCH_FLAG    = 1'b0;
    localparam logic [1:0]  LOCATE_TYPE      = 2'h0;
    localparam logic        SPACE_INDICATOR  = 1'b0;

    // Latency timer states.
    typedef enum logic [2:0] {
        LT_IDLE    = 3'b001,
        LT_COUNT   = 3'b010,
        LT_EXPIRED = 3'b100
    } pchr_lt_state_e;

endpackage

// file: pchr_regs.sv
`timescale 1ns/1ps

// Functional notes
// - Writable 8-bit master latency count at 0Ch bits 15-8, counted in PCI clocks.
// - Latency counter restarts at zero each time this device starts FRAME.
// - After expiry, end own transaction as soon as grant is removed; here the end request comes three clocks after the grant pin goes high.
// - Writable 8-bit line size at 0Ch bits 7-0, used by line transactions.
// - Self-test byte at 0Eh bits 15-8 reads zero; writes ignored.
// - Header layout byte reads zero: standard single-function header.
// - Writing all ones to base register at 10h reads back FFFF F800h.
// - Base register bits 31-11 are read/write window base pointer.
// - Base register bits 10-4 read zero, fixing a 2K-byte window.
// - Base register bit 3 reads zero: not prefetchable.
// - Base register bits 2-1 read zero: 32-bit base anywhere.
// - Base register bit 0 reads zero: memory space.
module pchr_regs #(
    parameter int WIN_ADDR_BITS = pchr_pkg::PTR_LSB
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        cfg_wr_en,
    input  wire logic        cfg_rd_en,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_rd_valid,
    input  wire logic        mst_frame_start,
    input  wire logic        mst_xfer_done,
    input  wire logic        pci_gnt_n,
    output logic             mst_end_req,
    output logic             mst_timer_expired,
    output logic [7:0]       line_size_setting,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             win_hit,
    output logic [31:0]      win_offset
);

    localparam int PTR_W = 32 - WIN_ADDR_BITS;
    localparam logic [31:0] BAR_ONES_READ = {{PTR_W{1'b1}}, {WIN_ADDR_BITS{1'b0}}};

    if (WIN_ADDR_BITS < 4 || WIN_ADDR_BITS > 31) begin : g_bad_window
        $error("pchr_regs: WIN_ADDR_BITS must lie between 4 and 31.");
    end

    logic [7:0]       timer_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic             gnt_meta_reg;
    logic             gnt_sync_reg;
    logic             sel_line_timer;
    logic             sel_win_base;
    logic [31:0]      wr_mask;
    logic [31:0]      rd_word;

    // Only the dword part of the address selects; the 0Eh byte pair shares
    // the 0Ch dword and is reached through byte lanes 2 and 3.
    assign sel_line_timer = (cfg_addr[7:2] == pchr_pkg::OFS_LINE_TIMER[7:2]);
    assign sel_win_base   = (cfg_addr[7:2] == pchr_pkg::OFS_WIN_BASE[7:2]);
    assign wr_mask        = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                             {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};

    // Line size and latency count; lanes 2 and 3 hold read-only bytes.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_size_setting <= pchr_pkg::LINE_TIMER_RESET[7:0];
            timer_reg         <= pchr_pkg::LINE_TIMER_RESET[15:8];
        end else if (cfg_wr_en && sel_line_timer) begin
            if (cfg_byte_en[0]) begin
                line_size_setting <= cfg_wdata[pchr_pkg::LINE_LSB +: 8];
            end
            if (cfg_byte_en[1]) begin
                timer_reg <= cfg_wdata[pchr_pkg::TIMER_LSB +: 8];
            end
        end
    end

    // Only the pointer bits are stored; the low bits are constants, so a
    // sizing write of all ones reads back as the window mask.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_reg <= pchr_pkg::WIN_BASE_RESET[31:WIN_ADDR_BITS];
        end else if (cfg_wr_en && sel_win_base) begin
            ptr_reg <= (ptr_reg & ~wr_mask[31:WIN_ADDR_BITS])
                     | (cfg_wdata[31:WIN_ADDR_BITS] & wr_mask[31:WIN_ADDR_BITS]);
        end
    end

    // Read multiplexer; unmapped dwords read as zero.
    always_comb begin
        rd_word = 32'h00000000;
        if (sel_line_timer) begin
            rd_word[pchr_pkg::LINE_LSB +: 8]     = line_size_setting;
            rd_word[pchr_pkg::TIMER_LSB +: 8]    = timer_reg;
            rd_word[pchr_pkg::HDR_LSB +: 8]      = pchr_pkg::HEADER_LAYOUT;
            rd_word[pchr_pkg::SELFTEST_LSB +: 8] = pchr_pkg::SELFTEST_VALUE;
        end else if (sel_win_base) begin
            rd_word[31:WIN_ADDR_BITS]             = ptr_reg;
            rd_word[pchr_pkg::PREFETCH_BIT]       = pchr_pkg::PREFETCH_FLAG;
            rd_word[pchr_pkg::LOCATE_LSB +: 2]    = pchr_pkg::LOCATE_TYPE;
            rd_word[pchr_pkg::SPACE_BIT]          = pchr_pkg::SPACE_INDICATOR;
        end
    end

    // Read data is registered and marked valid one clock after the request.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata    <= 32'h00000000;
            cfg_rd_valid <= 1'b0;
        end else begin
            cfg_rd_valid <= cfg_rd_en;
            if (cfg_rd_en) begin
                cfg_rdata <= rd_word;
            end
        end
    end

    // Grant arrives from the bus pin, so it is synchronised before use.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gnt_meta_reg <= 1'b1;
            gnt_sync_reg <= 1'b1;
        end else begin
            gnt_meta_reg <= pci_gnt_n;
            gnt_sync_reg <= gnt_meta_reg;
        end
    end

    pchr_lat_timer #(
        .TIMER_W       (8)
    ) u_lat_timer (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .timer_limit   (timer_reg),
        .frame_start   (mst_frame_start),
        .xfer_done     (mst_xfer_done),
        .gnt_n_sync    (gnt_sync_reg),
        .timer_expired (mst_timer_expired),
        .end_req       (mst_end_req)
    );

    // Window decode; the offset keeps the address bits below the pointer.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_hit    <= 1'b0;
            win_offset <= 32'h00000000;
        end else begin
            win_hit    <= mem_req && (mem_addr[31:WIN_ADDR_BITS] == ptr_reg);
            win_offset <= {{PTR_W{1'b0}}, mem_addr[WIN_ADDR_BITS-1:0]};
        end
    end

    sequence s_bar_ones;
        cfg_wr_en && sel_win_base && (cfg_byte_en == 4'hf) && (cfg_wdata == 32'hffffffff);
    endsequence

    sequence s_bar_read;
        cfg_rd_en && !cfg_wr_en && sel_win_base;
    endsequence

    a_bar_allones: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_bar_ones ##1 s_bar_read |=> cfg_rd_valid && (cfg_rdata == BAR_ONES_READ))
        else $error("Sizing read of base register gave wrong mask.");

    a_bar_low_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_rd_en && sel_win_base |=> cfg_rdata[WIN_ADDR_BITS-1:0] == '0)
        else $error("Base register low bits did not read zero.");

    a_bar_ptr_rw: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_bar_ones |=> ptr_reg == {PTR_W{1'b1}})
        else $error("Base pointer did not take a full write.");

    a_line_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_wr_en && sel_line_timer && cfg_byte_en[0]
        |=> line_size_setting == $past(cfg_wdata[7:0]))
        else $error("Line size write was not stored.");

    a_timer_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_wr_en && sel_line_timer && cfg_byte_en[1]
        |=> timer_reg == $past(cfg_wdata[15:8]))
        else $error("Latency count write was not stored.");

    a_selftest_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_rd_en && sel_line_timer |=> cfg_rd_valid && (cfg_rdata[31:24] == 8'h00))
        else $error("Self-test byte did not read zero.");

    a_header_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_rd_en && sel_line_timer |=> cfg_rdata[23:16] == 8'h00)
        else $error("Header layout byte did not read zero.");

    a_window_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mem_req && (mem_addr[31:WIN_ADDR_BITS] == ptr_reg)
        |=> win_hit && (win_offset == {{PTR_W{1'b0}}, $past(mem_addr[WIN_ADDR_BITS-1:0])}))
        else $error("Window access not claimed or offset wrong.");

endmodule

// file: pci_config_header_regs_tb.sv
`timescale 1ns/1ps

// Self-checking bench for the configuration header registers.
module pci_config_header_regs_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [3:0]  cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000, cfg_rdata, win_offset;
    logic        cfg_rd_valid, mst_end_req, mst_timer_expired, win_hit, pci_gnt_n;
    logic        mst_frame_start = 1'b0, mst_xfer_done = 1'b0, hold_grant = 1'b1;
    logic        mem_req = 1'b0;
    logic [31:0] mem_addr = 32'h00000000;
    logic [7:0]  line_size_setting;
    logic [31:0] rd;
    int          miscompares = 0, cmp_count = 0, cycles = 0, i;

    // Clock of 10 ns period.
    always #5 ref_clk = ~ref_clk;

    pchr_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_wr_en(cfg_wr_en),
        .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
        .mst_frame_start(mst_frame_start), .mst_xfer_done(mst_xfer_done),
        .pci_gnt_n(pci_gnt_n), .mst_end_req(mst_end_req),
        .mst_timer_expired(mst_timer_expired), .line_size_setting(line_size_setting),
        .mem_req(mem_req), .mem_addr(mem_addr), .win_hit(win_hit), .win_offset(win_offset));

    pchr_arb_model arb (.ref_clk(ref_clk), .reset_n(reset_n), .hold_grant(hold_grant),
        .pci_gnt_n(pci_gnt_n));

    // Compare one value and count it; four-state equality keeps X from passing.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hung handshake would stall the run, so a ceiling cuts it short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // One-cycle write strobe with byte lanes.
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        cfg_wr_en <= 1'b1;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr_en <= 1'b0;
    endtask

    // Read answers on the same edge that takes the strobe, one cycle after it is raised.
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        cfg_rd_en <= 1'b1;
        cfg_addr <= a;
        @(posedge ref_clk);
        cfg_rd_en <= 1'b0;
        #1;
        check("read valid", {31'h0, cfg_rd_valid}, 32'h1);
        d = cfg_rdata;
    endtask

    // One-cycle pulse on the frame start (is_frame high) or on transfer done.
    // Both are lowered together, so a second call never meets a raised strobe.
    task automatic pulse(input bit is_frame);
        @(posedge ref_clk);
        if (is_frame) begin
            mst_frame_start <= 1'b1;
        end else begin
            mst_xfer_done <= 1'b1;
        end
        @(posedge ref_clk);
        mst_frame_start <= 1'b0;
        mst_xfer_done   <= 1'b0;
    endtask

    task automatic decode(input logic [31:0] a, input logic hit);
        @(posedge ref_clk);
        mem_req <= 1'b1;
        mem_addr <= a;
        @(posedge ref_clk);
        mem_req <= 1'b0;
        #1;
        check("window hit", {31'h0, win_hit}, {31'h0, hit});
        check("window offset", win_offset, {21'h0, a[10:0]});
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        // Reset values and an unmapped dword.
        cfg_read(8'h0c, rd);
        check("line timer reset", rd, 32'h00000000);
        cfg_read(8'h10, rd);
        check("base reset", rd, 32'h00000000);
        cfg_read(8'h20, rd);
        check("unmapped read", rd, 32'h00000000);
        $display("test reset values done");
        // All ones to 0Ch: the header and self-test lanes stay zero.
        cfg_write(8'h0c, 4'hf, 32'hffffffff);
        cfg_read(8'h0c, rd);
        check("line timer all ones", rd, 32'h0000ffff);
        check("line size port", {24'h0, line_size_setting}, 32'h000000ff);
        cfg_write(8'h0c, 4'h1, 32'h12345678);
        cfg_read(8'h0c, rd);
        check("line size lane", rd, 32'h0000ff78);
        $display("test line and timer done");
        // Sizing probe of the window base read back in the very next cycle.
        @(posedge ref_clk);
        cfg_wr_en   <= 1'b1;
        cfg_addr    <= 8'h10;
        cfg_byte_en <= 4'hf;
        cfg_wdata   <= 32'hffffffff;
        @(posedge ref_clk);
        cfg_wr_en <= 1'b0;
        cfg_rd_en <= 1'b1;
        @(posedge ref_clk);
        cfg_rd_en <= 1'b0;
        #1;
        check("sizing valid", {31'h0, cfg_rd_valid}, 32'h1);
        check("base sizing", cfg_rdata, 32'hfffff800);
        cfg_write(8'h10, 4'hf, 32'ha5a5a5a5);
        cfg_read(8'h10, rd);
        check("base pointer", rd, 32'ha5a5a000);
        decode(32'ha5a5a07f, 1'b1);
        decode(32'ha5a5a7ff, 1'b1);
        decode(32'ha5a5a800, 1'b0);
        decode(32'ha5a5b000, 1'b0);
        $display("test window base done");
        // Latency count of 2 clocks with the grant kept.
        cfg_write(8'h0c, 4'h2, 32'h00000200);
        pulse(1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        check("expired early", {31'h0, mst_timer_expired}, 32'h0);
        @(posedge ref_clk);
        #1;
        check("expired on time", {31'h0, mst_timer_expired}, 32'h1);
        repeat (4) @(posedge ref_clk);
        #1;
        check("no end while granted", {31'h0, mst_end_req}, 32'h0);
        // Grant removed: the end request must follow within a few clocks.
        hold_grant <= 1'b0;
        for (i = 0; i < 8 && mst_end_req !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check("end after grant loss", {31'h0, mst_end_req}, 32'h1);
        pulse(1'b0);
        #1;
        check("end cleared", {31'h0, mst_end_req}, 32'h0);
        // The expired level drops one clock after the done pulse is taken.
        @(posedge ref_clk);
        #1;
        check("expired cleared", {31'h0, mst_timer_expired}, 32'h0);
        $display("test latency expiry done");
        // A new frame arriving just as the count expires restarts from zero.
        pulse(1'b1);
        repeat (2) @(posedge ref_clk);
        pulse(1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        check("restart not expired", {31'h0, mst_timer_expired}, 32'h0);
        @(posedge ref_clk);
        #1;
        check("restart expired", {31'h0, mst_timer_expired}, 32'h1);
        $display("test frame restart done");
        report_and_stop();
    end
endmodule
